/* File: src/floppy_ctrl_config_regs.sv */
// floppy controller configuration register bank with drive pin steering
//
// The strobed register port was decided locally.
`timescale 1ns/1ps

module floppy_ctrl_config_regs (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  input  wire fdc_cfg_pkg::reg_req_t i_req,
  output logic [7:0]                 o_rdata,
  input  wire fdc_cfg_pkg::ctl_out_t i_ctl,
  input  wire logic [4:0]            i_drv_pins,
  output logic [6:0]                 o_drv_pins,
  output logic                       o_pullup_en,
  output fdc_cfg_pkg::drv_stat_t     o_drv_stat,
  output logic                       o_status_a_second_drive,
  output logic [1:0]                 o_tape_media_bits,
  output logic                       o_dma_burst,
  output logic                       o_three_mode,
  output fdc_cfg_pkg::if_mode_t      o_if_mode,
  output logic                       o_if_mode_reserved,
  output logic [1:0]                 o_boot_drive,
  output logic [7:0]                 o_drive_types,
  output logic [6:0]                 o_drive_a_extra
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]            drive_interface_config;
  logic [7:0]            boot_media_write_control;
  logic [7:0]            drive_type_select;
  logic [7:0]            drive_a_extra_config;
  fdc_cfg_pkg::drv_cfg_t cfg;
  logic [7:0]            next_rdata;

  // write hit on a given offset
  function automatic logic wr_hit(input fdc_cfg_pkg::reg_req_t rq, input logic [7:0] a);
    wr_hit = rq.wr && (rq.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // register writes, one process per register
  // ----------------------------------------------------------------
  // interface config: defaults to pull-ups off, compat-c mode, non-burst DMA
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      drive_interface_config <= fdc_cfg_pkg::RST_DRIVE_INTERFACE_CONFIG;
    end else if (wr_hit(i_req, fdc_cfg_pkg::ADDR_DRIVE_INTERFACE_CONFIG)) begin
      drive_interface_config <= i_req.wdata;
    end
  end

  // boot / media / write control
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      boot_media_write_control <= fdc_cfg_pkg::RST_BOOT_MEDIA_WRITE_CONTROL;
    end else if (wr_hit(i_req, fdc_cfg_pkg::ADDR_BOOT_MEDIA_WRITE_CONTROL)) begin
      boot_media_write_control <= i_req.wdata;
    end
  end

  // per-drive type fields, opaque here
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      drive_type_select <= fdc_cfg_pkg::RST_DRIVE_TYPE_SELECT;
    end else if (wr_hit(i_req, fdc_cfg_pkg::ADDR_DRIVE_TYPE_SELECT)) begin
      drive_type_select <= i_req.wdata;
    end
  end

  // extra config: top bit reserved, kept at zero so it reads zero
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      drive_a_extra_config <= fdc_cfg_pkg::RST_DRIVE_A_EXTRA_CONFIG;
    end else if (wr_hit(i_req, fdc_cfg_pkg::ADDR_DRIVE_A_EXTRA_CONFIG)) begin
      drive_a_extra_config <= i_req.wdata & fdc_cfg_pkg::MASK_DRIVE_A_EXTRA_CONFIG;
    end
  end

  // ----------------------------------------------------------------
  // field decode, combinational so a write acts on the next edge
  // ----------------------------------------------------------------
  always_comb begin
    cfg.pullup_disable     = drive_interface_config[fdc_cfg_pkg::BIT_PULLUP_DISABLE];
    cfg.polarity_high      = drive_interface_config[fdc_cfg_pkg::BIT_POLARITY_HIGH];
    cfg.second_drive_n     = drive_interface_config[fdc_cfg_pkg::BIT_SECOND_DRV_N];
    cfg.swap_drives        = drive_interface_config[fdc_cfg_pkg::BIT_SWAP_DRIVES];
    cfg.if_mode            = fdc_cfg_pkg::if_mode_t'(
                               drive_interface_config[fdc_cfg_pkg::POS_IF_MODE +: 2]);
    cfg.dma_non_burst      = drive_interface_config[fdc_cfg_pkg::BIT_DMA_NON_BURST];
    cfg.three_mode         = drive_interface_config[fdc_cfg_pkg::BIT_THREE_MODE];
    cfg.media_id           = boot_media_write_control[fdc_cfg_pkg::POS_MEDIA_ID +: 2];
    cfg.density_sel        = boot_media_write_control[fdc_cfg_pkg::POS_DENSITY_SEL +: 2];
    cfg.write_inhibit      = boot_media_write_control[fdc_cfg_pkg::BIT_WRITE_INHIBIT];
    cfg.soft_write_protect = boot_media_write_control[fdc_cfg_pkg::BIT_SOFT_WR_PROTECT];
  end

  // ----------------------------------------------------------------
  // controller-facing mode outputs
  // ----------------------------------------------------------------
  // pull-ups are live when the control bit is clear
  assign o_pullup_en = ~cfg.pullup_disable;
  // burst is the low state of the DMA mode bit; reset sets the bit high for non-burst
  assign o_dma_burst = ~cfg.dma_non_burst;
  assign o_three_mode = cfg.three_mode;
  assign o_boot_drive = boot_media_write_control[fdc_cfg_pkg::POS_BOOT_DRIVE +: 2];
  assign o_drive_types = drive_type_select;
  assign o_drive_a_extra = drive_a_extra_config[6:0];

  // mode decode; reserved code falls back to compat-c and is flagged
  always_comb begin
    case (cfg.if_mode)
      fdc_cfg_pkg::IF_MODEL30: begin
        o_if_mode          = fdc_cfg_pkg::IF_MODEL30;
        o_if_mode_reserved = 1'b0;
      end
      fdc_cfg_pkg::IF_COMPAT_B: begin
        o_if_mode          = fdc_cfg_pkg::IF_COMPAT_B;
        o_if_mode_reserved = 1'b0;
      end
      fdc_cfg_pkg::IF_COMPAT_C: begin
        o_if_mode          = fdc_cfg_pkg::IF_COMPAT_C;
        o_if_mode_reserved = 1'b0;
      end
      default: begin
        o_if_mode          = fdc_cfg_pkg::IF_COMPAT_C;
        o_if_mode_reserved = 1'b1;
      end
    endcase
  end

  // second drive shown only in compat-b mode, bit is active low
  assign o_status_a_second_drive = (cfg.if_mode == fdc_cfg_pkg::IF_COMPAT_B)
                                   && !cfg.second_drive_n;

  // tape register bits 7..6 copy the media identifier
  assign o_tape_media_bits = cfg.media_id;

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    case (i_req.addr)
      fdc_cfg_pkg::ADDR_DRIVE_INTERFACE_CONFIG:   next_rdata = drive_interface_config;
      fdc_cfg_pkg::ADDR_BOOT_MEDIA_WRITE_CONTROL: next_rdata = boot_media_write_control;
      fdc_cfg_pkg::ADDR_DRIVE_TYPE_SELECT:        next_rdata = drive_type_select;
      fdc_cfg_pkg::ADDR_DRIVE_A_EXTRA_CONFIG:     next_rdata = drive_a_extra_config;
      default:                                    next_rdata = 8'h00;
    endcase
  end

  // read data held only in the answer cycle; zero otherwise
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_req.rd ? next_rdata : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // drive pin logic
  // ----------------------------------------------------------------
  fdc_pin_adapt u_pins (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_cfg     (cfg),
    .i_ctl     (i_ctl),
    .i_pins    (i_drv_pins),
    .o_pins    (o_drv_pins),
    .o_stat    (o_drv_stat)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    i_req.wr && i_req.addr == fdc_cfg_pkg::ADDR_DRIVE_INTERFACE_CONFIG;
  endsequence

  property p_pullup;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s_cfg_write |=> (o_pullup_en == ~$past(i_req.wdata[7]));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup enable wrong");

  property p_polarity_we;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !cfg.write_inhibit && $stable(cfg.polarity_high) |=>
        o_drv_pins[4] == ($past(cfg.polarity_high) ? $past(i_ctl.write_enable)
                                                   : ~$past(i_ctl.write_enable));
  endproperty
  a_polarity_we: assert property (p_polarity_we) else $error("write enable polarity wrong");

  property p_second;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_status_a_second_drive == (drive_interface_config[3:2] == 2'h1
                                  && !drive_interface_config[5]);
  endproperty
  a_second: assert property (p_second) else $error("second drive report wrong");

  property p_swap;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      cfg.swap_drives && !cfg.polarity_high && $stable(cfg) |=>
        o_drv_pins[0] == ~$past(i_ctl.drive_sel[1]);
  endproperty
  a_swap: assert property (p_swap) else $error("drive select swap wrong");

  property p_mode;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_if_mode_reserved == (drive_interface_config[3:2] == 2'h2);
  endproperty
  a_mode: assert property (p_mode) else $error("reserved mode flag wrong");

  property p_dma;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s_cfg_write ##1 1'b1 |-> o_dma_burst == ~$past(i_req.wdata[1]);
  endproperty
  a_dma: assert property (p_dma) else $error("dma burst wrong");

  property p_three;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s_cfg_write |=> o_three_mode == $past(i_req.wdata[0]);
  endproperty
  a_three: assert property (p_three) else $error("three mode wrong");

  property p_media;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_req.wr && i_req.addr == fdc_cfg_pkg::ADDR_BOOT_MEDIA_WRITE_CONTROL |=>
        o_tape_media_bits == $past(i_req.wdata[5:4]);
  endproperty
  a_media: assert property (p_media) else $error("media bits wrong");

  property p_dens;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      cfg.density_sel[1] && $stable(cfg.density_sel) |=>
        o_drv_pins[6] == ~$past(cfg.density_sel[0]);
  endproperty
  a_dens: assert property (p_dens) else $error("density force wrong");

  property p_winh;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      cfg.write_inhibit [*2] |-> o_drv_pins[5:4] == 2'h3;
  endproperty
  a_winh: assert property (p_winh) else $error("write pins not held high");

  property p_soft_write_protect;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      cfg.soft_write_protect |=> o_drv_stat.write_protect;
  endproperty
  a_soft_write_protect: assert property (p_soft_write_protect) else $error("soft write protect ignored");

  property p_reset;
    @(posedge i_sys_clk) i_sys_rst |=>
      drive_interface_config == fdc_cfg_pkg::RST_DRIVE_INTERFACE_CONFIG
      && boot_media_write_control == fdc_cfg_pkg::RST_BOOT_MEDIA_WRITE_CONTROL
      && drive_type_select == fdc_cfg_pkg::RST_DRIVE_TYPE_SELECT
      && drive_a_extra_config == fdc_cfg_pkg::RST_DRIVE_A_EXTRA_CONFIG;
  endproperty
  a_reset: assert property (p_reset) else $error("reset defaults wrong");

  // read answer stands one cycle after the strobe, zero otherwise
  sequence s_rd_cfg;
    i_req.rd && i_req.addr == fdc_cfg_pkg::ADDR_DRIVE_INTERFACE_CONFIG;
  endsequence

  property p_rd_cfg;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s_rd_cfg |=> o_rdata == $past(drive_interface_config);
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read data wrong");

  property p_rd_idle;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !i_req.rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");

  // unmapped offset in the bank reads zero
  property p_rd_hole;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      i_req.rd && i_req.addr == 8'hF3 |=> o_rdata == 8'h00;
  endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");

  property p_extra_mask;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !drive_a_extra_config[7];
  endproperty
  a_extra_mask: assert property (p_extra_mask) else $error("reserved extra bit set");

  // pins follow the polarity in force when they were launched
  property p_sel1_pol;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !cfg.swap_drives |=>
        o_drv_pins[1] == ($past(cfg.polarity_high) ? $past(i_ctl.drive_sel[1])
                                                   : !$past(i_ctl.drive_sel[1]));
  endproperty
  a_sel1_pol: assert property (p_sel1_pol) else $error("drive select level wrong");

  property p_swap_motor;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      cfg.swap_drives && cfg.polarity_high |=> o_drv_pins[3] == $past(i_ctl.motor_on[0]);
  endproperty
  a_swap_motor: assert property (p_swap_motor) else $error("motor swap wrong");

  property p_dens_norm;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !cfg.density_sel[1] |=>
        o_drv_pins[6] == ($past(cfg.polarity_high) ? $past(i_ctl.density)
                                                   : !$past(i_ctl.density));
  endproperty
  a_dens_norm: assert property (p_dens_norm) else $error("density level wrong");

  property p_wd_pol;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !cfg.write_inhibit |=>
        o_drv_pins[5] == ($past(cfg.polarity_high) ? $past(i_ctl.write_data)
                                                   : !$past(i_ctl.write_data));
  endproperty
  a_wd_pol: assert property (p_wd_pol) else $error("write data level wrong");

  // status path is pin, two sync stages, output flop; sync flops hold reset for two edges
  sequence s_sync_live;
    !$past(i_sys_rst) && !$past(i_sys_rst, 2);
  endsequence

  property p_wp_pin;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s_sync_live ##0 (!cfg.polarity_high && !cfg.soft_write_protect) |=>
        o_drv_stat.write_protect == !$past(i_drv_pins[4], 3);
  endproperty
  a_wp_pin: assert property (p_wp_pin) else $error("write protect pin ignored");

  property p_index_pin;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s_sync_live ##0 cfg.polarity_high |=> o_drv_stat.index == $past(i_drv_pins[1], 3);
  endproperty
  a_index_pin: assert property (p_index_pin) else $error("index level wrong");

endmodule

/* File: src/fdc_cfg_pkg.sv */
// package: register map, field positions, resets and carrier types for the floppy config bank
package fdc_cfg_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DRIVE_INTERFACE_CONFIG   = 8'hF0;
  localparam logic [7:0] ADDR_BOOT_MEDIA_WRITE_CONTROL = 8'hF1;
  localparam logic [7:0] ADDR_DRIVE_TYPE_SELECT        = 8'hF2;
  localparam logic [7:0] ADDR_DRIVE_A_EXTRA_CONFIG     = 8'hF4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DRIVE_INTERFACE_CONFIG   = 8'h8E;
  localparam logic [7:0] RST_BOOT_MEDIA_WRITE_CONTROL = 8'h00;
  localparam logic [7:0] RST_DRIVE_TYPE_SELECT        = 8'hFF;
  localparam logic [7:0] RST_DRIVE_A_EXTRA_CONFIG     = 8'h00;
  // only bits 6..0 of the extra config register are writable
  localparam logic [7:0] MASK_DRIVE_A_EXTRA_CONFIG    = 8'h7F;

  // ----------------------------------------------------------------
  // field positions, drive interface config
  // ----------------------------------------------------------------
  localparam int BIT_PULLUP_DISABLE = 7;
  localparam int BIT_POLARITY_HIGH  = 6;
  localparam int BIT_SECOND_DRV_N   = 5;
  localparam int BIT_SWAP_DRIVES    = 4;
  localparam int POS_IF_MODE        = 2;
  localparam int BIT_DMA_NON_BURST  = 1;
  localparam int BIT_THREE_MODE     = 0;

  // field positions, boot / media / write control
  localparam int POS_BOOT_DRIVE      = 6;
  localparam int POS_MEDIA_ID        = 4;
  localparam int POS_DENSITY_SEL     = 2;
  localparam int BIT_WRITE_INHIBIT   = 1;
  localparam int BIT_SOFT_WR_PROTECT = 0;

  // density select codes
  localparam logic [1:0] DENS_FORCE_ONE  = 2'h2;
  localparam logic [1:0] DENS_FORCE_ZERO = 2'h3;

  // interface mode encoding
  typedef enum logic [1:0] {
    IF_MODEL30  = 2'b00,
    IF_COMPAT_B = 2'b01,
    IF_RESERVED = 2'b10,
    IF_COMPAT_C = 2'b11
  } if_mode_t;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // decoded configuration handed to the pin logic
  typedef struct packed {
    logic       pullup_disable;
    logic       polarity_high;
    logic       second_drive_n;
    logic       swap_drives;
    if_mode_t   if_mode;
    logic       dma_non_burst;
    logic       three_mode;
    logic [1:0] media_id;
    logic [1:0] density_sel;
    logic       write_inhibit;
    logic       soft_write_protect;
  } drv_cfg_t;

  // controller-side (active high, logical) drive signals
  typedef struct packed {
    logic [1:0] drive_sel;
    logic [1:0] motor_on;
    logic       write_enable;
    logic       write_data;
    logic       density;
  } ctl_out_t;

  // logical status coming back from drive pins
  typedef struct packed {
    logic read_data;
    logic index;
    logic track_zero;
    logic disk_change;
    logic write_protect;
  } drv_stat_t;

endpackage

/* File: src/fdc_pin_adapt.sv */
// drive pin adapter: polarity, swap, write inhibit, density forcing, status sync
`timescale 1ns/1ps
module fdc_pin_adapt (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  input  wire fdc_cfg_pkg::drv_cfg_t i_cfg,
  input  wire fdc_cfg_pkg::ctl_out_t i_ctl,
  input  wire logic [4:0]            i_pins,
  output logic [6:0]                 o_pins,
  output fdc_cfg_pkg::drv_stat_t     o_stat
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // logical level to pin level: active low inverts
  function automatic logic to_pin(input logic lv, input logic pol_high);
    to_pin = pol_high ? lv : ~lv;
  endfunction

  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [1:0] sel_eff;
  logic [1:0] mot_eff;
  logic       dens_eff;
  logic [4:0] log_in;

  // ----------------------------------------------------------------
  // two-stage sync on drive status pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sync_a <= 5'h1F;
      sync_b <= 5'h1F;
    end else begin
      sync_a <= i_pins;
      sync_b <= sync_a;
    end
  end

  // drive 0/1 exchange and density forcing
  always_comb begin
    sel_eff = i_cfg.swap_drives ? {i_ctl.drive_sel[0], i_ctl.drive_sel[1]}
                                : i_ctl.drive_sel;
    mot_eff = i_cfg.swap_drives ? {i_ctl.motor_on[0], i_ctl.motor_on[1]}
                                : i_ctl.motor_on;
    case (i_cfg.density_sel)
      fdc_cfg_pkg::DENS_FORCE_ONE:  dens_eff = 1'b1;
      fdc_cfg_pkg::DENS_FORCE_ZERO: dens_eff = 1'b0;
      default:                      dens_eff = to_pin(i_ctl.density,
                                                      i_cfg.polarity_high);
    endcase
  end

  // registered pin outputs; write pins forced high when inhibited
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_pins <= 7'h7F;
    end else begin
      o_pins[0] <= to_pin(sel_eff[0], i_cfg.polarity_high);
      o_pins[1] <= to_pin(sel_eff[1], i_cfg.polarity_high);
      o_pins[2] <= to_pin(mot_eff[0], i_cfg.polarity_high);
      o_pins[3] <= to_pin(mot_eff[1], i_cfg.polarity_high);
      o_pins[4] <= i_cfg.write_inhibit ? 1'b1
                 : to_pin(i_ctl.write_enable, i_cfg.polarity_high);
      o_pins[5] <= i_cfg.write_inhibit ? 1'b1
                 : to_pin(i_ctl.write_data, i_cfg.polarity_high);
      o_pins[6] <= dens_eff;
    end
  end

  // status pins to logical levels
  assign log_in = i_cfg.polarity_high ? sync_b : ~sync_b;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_stat <= '0;
    end else begin
      o_stat.read_data     <= log_in[0];
      o_stat.index         <= log_in[1];
      o_stat.track_zero    <= log_in[2];
      o_stat.disk_change   <= log_in[3];
      o_stat.write_protect <= i_cfg.soft_write_protect | log_in[4];
    end
  end

endmodule

/* File: verif/fdc_drive_model.sv */
// behavioural floppy drive on the far side of the pin adapter
`timescale 1ns/1ps
module fdc_drive_model (
  input  wire logic                  i_sys_clk,
  input  wire logic [6:0]            i_drv_pins,
  input  wire logic                  i_pullup_en,
  input  wire logic                  i_polarity_high,
  input  wire fdc_cfg_pkg::drv_stat_t i_stat,
  output logic [4:0]                 o_pins
);
  logic [4:0] level = 5'h1F;
  logic       selected;
  logic [4:0] lvl_logic;

  // either drive select asserted at pin level means the drive answers
  assign selected  = i_polarity_high ? (i_drv_pins[0] | i_drv_pins[1])
                                     : ~(i_drv_pins[0] & i_drv_pins[1]);
  assign lvl_logic = {i_stat.write_protect, i_stat.disk_change, i_stat.track_zero,
                      i_stat.index, i_stat.read_data};

  // deselected lines float: pulled high, or wander when the pull-ups are off
  always @(posedge i_sys_clk) begin
    if (selected)
      level <= i_polarity_high ? lvl_logic : ~lvl_logic;
    else if (i_pullup_en)
      level <= 5'h1F;
    else
      level <= ~level; // no pull-up: never trust a stale level
  end
  assign o_pins = level;
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the floppy configuration register bank
`timescale 1ns/1ps
module testbench;
  logic                     sys_clk = 1'b0;
  logic                     sys_rst = 1'b1;
  fdc_cfg_pkg::reg_req_t    req = '0;
  fdc_cfg_pkg::ctl_out_t    ctl = '0;
  fdc_cfg_pkg::drv_stat_t   stat_l = '0;
  fdc_cfg_pkg::drv_stat_t   drv_stat;
  fdc_cfg_pkg::if_mode_t    if_mode;
  logic [4:0]               raw;
  logic [6:0]               pins;
  logic [7:0]               rdata, types;
  logic [6:0]               extra;
  logic [1:0]               media, boot;
  logic                     pu_en, sec_drv, if_res, burst, three;
  logic                     pol = 1'b0;
  logic                     rd_seen = 1'b0;
  logic [7:0]               exp_q[$];
  int                       errors = 0;
  int                       check_count = 0;

  // ----------------------------------------------------------------
  // clock, design and drive model
  // ----------------------------------------------------------------
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  floppy_ctrl_config_regs floppy_ctrl_config_regs_i (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_req(req), .o_rdata(rdata),
    .i_ctl(ctl), .i_drv_pins(raw), .o_drv_pins(pins), .o_pullup_en(pu_en),
    .o_drv_stat(drv_stat), .o_status_a_second_drive(sec_drv),
    .o_tape_media_bits(media), .o_dma_burst(burst), .o_three_mode(three),
    .o_if_mode(if_mode), .o_if_mode_reserved(if_res), .o_boot_drive(boot),
    .o_drive_types(types), .o_drive_a_extra(extra)
  );

  fdc_drive_model fdc_drive_model_i (
    .i_sys_clk(sys_clk), .i_drv_pins(pins), .i_pullup_en(pu_en),
    .i_polarity_high(pol), .i_stat(stat_l), .o_pins(raw)
  );

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask

  // read data is noted now and compared by the monitor a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(exp);
  endtask

  task automatic idle;
    @(posedge sys_clk);
    req <= '0;
  endtask

  task automatic rd_defaults;
    rd(fdc_cfg_pkg::ADDR_DRIVE_INTERFACE_CONFIG, 8'h8E);
    rd(fdc_cfg_pkg::ADDR_BOOT_MEDIA_WRITE_CONTROL, 8'h00);
    rd(fdc_cfg_pkg::ADDR_DRIVE_TYPE_SELECT, 8'hFF);
    rd(fdc_cfg_pkg::ADDR_DRIVE_A_EXTRA_CONFIG, 8'h00);
    rd(8'hF3, 8'h00);
    idle;
  endtask

  // expected pin levels worked out from config and controller intent
  function automatic logic [6:0] exp_pins(input logic [7:0] f0, input logic [7:0] f1,
                                          input fdc_cfg_pkg::ctl_out_t c);
    logic [1:0] s;
    logic [1:0] m;
    logic [6:0] p;
    s = f0[4] ? {c.drive_sel[0], c.drive_sel[1]} : c.drive_sel;
    m = f0[4] ? {c.motor_on[0], c.motor_on[1]} : c.motor_on;
    p = {c.density, c.write_data, c.write_enable, m, s};
    if (!f0[6])
      p = ~p;
    if (f1[1])
      p[5:4] = 2'b11;
    if (f1[3:2] == 2'b10)
      p[6] = 1'b1;
    else if (f1[3:2] == 2'b11)
      p[6] = 1'b0;
    return p;
  endfunction

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_seen)
      chk(rdata, exp_q.pop_front());
    rd_seen <= req.rd;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]             v, w, d;
    logic [7:0]             a[4];
    logic [7:0]             t[5];
    fdc_cfg_pkg::ctl_out_t  c;
    fdc_cfg_pkg::drv_stat_t s;
    a = '{8'hF0, 8'hF1, 8'hF2, 8'hF4};
    void'($urandom(12590));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_defaults();
    // back-to-back write then read on every register, plus a hole
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      t[i] = d;
      wr((i < 4) ? a[i] : 8'hF3, d);
      rd((i < 4) ? a[i] : 8'hF3, (i == 4) ? 8'h00 : (i == 3) ? (d & 8'h7F) : d);
    end
    idle;
    // every mode and density code, random remaining fields
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom);
      v[3:2] = 2'(i);
      w = 8'($urandom);
      w[3:2] = 2'(i >> 2);
      c = fdc_cfg_pkg::ctl_out_t'(7'($urandom));
      c.drive_sel[0] = 1'b1; // keep the drive answering
      s = fdc_cfg_pkg::drv_stat_t'(5'($urandom));
      @(posedge sys_clk);
      ctl <= c;
      stat_l <= s;
      pol <= v[6];
      wr(8'hF0, v);
      wr(8'hF1, w);
      idle;
      repeat (8) @(posedge sys_clk);
      #1;
      chk(8'(pu_en), 8'(!v[7]));
      chk(8'(pins), 8'(exp_pins(v, w, c)));
      chk(8'(sec_drv), 8'(v[3:2] == 2'b01 && !v[5]));
      chk(8'(if_mode), 8'((v[3:2] == 2'b10) ? 2'b11 : v[3:2]));
      chk(8'(if_res), 8'(v[3:2] == 2'b10));
      chk(8'(burst), 8'(!v[1]));
      chk(8'(three), 8'(v[0]));
      chk(8'(media), 8'(w[5:4]));
      chk(8'(boot), 8'(w[7:6]));
      s.write_protect = s.write_protect | w[0];
      chk(8'(drv_stat), 8'(s));
    end
    chk(types, t[2]);
    chk(8'(extra), t[3] & 8'h7F);
    // reset in mid-run brings defaults back
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_defaults();
    repeat (2) @(posedge sys_clk);
    #1;
    chk(8'(pu_en), 8'h00);
    chk(types, 8'hFF);
    chk(8'(extra), 8'h00);
    close_out();
  end
endmodule
